// ### hw/dram_power_state_and_mode_program.sv
// Contract
// R01: Transition uses current and previous clock gate.
// R02: Power-down entry/exit carries deselect only.
// R03: Self-refresh exit deselect, or gear-down nop.
// R04: Self-refresh only from idle, refresh plus fall.
// R05: No self-refresh entry during read or write.
// R06: Closed banks give precharge power-down, else active.
// R07: No refresh performed while powered down.
// R08: Clock gate held until minimum pulse met.
// R09: Deselect through exit wait; reads after locked.
// R10: Termination ignored for states; off in self-refresh.
// R11: Seven mode registers written by mode write.
// R12: Controller writes mode registers after reset.
// R13: Mode write carries every field valid.
// R14: Mode writes leave array contents untouched.
// R15: Mode write only while idle.
// R16: Mode write gap between two mode writes.
// R17: Mode-to-command gap before non-deselect commands.
// R18: Next mode write after function update.
// R19: Termination low around nominal termination change.
// R20: Termination ignored when nominal off both sides.
// R21: Reserved first mode register bits zero.
// R22: Write recovery field sets autoprecharge write delay; the field is only stored here.
// R23: Command decoded from pins at rising edge.
// R24: Explicit state register; unlisted transitions flagged.
`timescale 1ns/1ps
module dram_power_state_and_mode_program (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire dram_pwr_pkg::cmd_pins_s cmd_pins_in,
    input wire logic termination_control_in,
    input wire logic gear_down_in,
    output logic [5:0] power_state_out,
    output logic unsupported_out,
    output logic refresh_active_out,
    output logic termination_enable_out,
    output logic mode_write_out,
    output logic [2:0] mode_index_out,
    output logic [13:0] mode_value_out
);
    // Pins come from outside the clock domain; two stages before use.
    dram_pwr_pkg::cmd_pins_s pins_meta_reg;
    dram_pwr_pkg::cmd_pins_s pins_reg;
    logic term_meta_reg;
    logic term_reg;
    logic gear_meta_reg;
    logic gear_reg;
    logic gate_prev_reg;
    dram_pwr_pkg::power_state_e state_reg;
    dram_pwr_pkg::power_state_e state_next;
    dram_pwr_pkg::power_state_e busy_return_reg;
    logic [3:0] busy_count_reg;
    logic [7:0] open_banks_reg;
    logic [13:0] mode_regs_reg [dram_pwr_pkg::MODE_REG_COUNT];
    logic unsupported_reg;
    logic refresh_reg;
    logic term_en_reg;
    logic mode_wr_reg;
    logic [2:0] mode_idx_reg;
    logic [13:0] mode_val_reg;

    function automatic dram_pwr_pkg::command_e decode_cmd(input dram_pwr_pkg::cmd_pins_s p);
        logic [2:0] rcw;
        rcw = {p.ras_n, p.cas_n, p.we_n};
        if (p.chip_select_n)
            return dram_pwr_pkg::CMD_DESELECT;
        if (!p.activate_n)
            return dram_pwr_pkg::CMD_ACTIVATE;
        case (rcw)
            3'h0: return dram_pwr_pkg::CMD_MODE_WR;
            3'h1: return dram_pwr_pkg::CMD_REFRESH;
            3'h2: return dram_pwr_pkg::CMD_PRECHARGE;
            3'h3: return dram_pwr_pkg::CMD_RESERVED;
            3'h4: return dram_pwr_pkg::CMD_WRITE;
            3'h5: return dram_pwr_pkg::CMD_READ;
            3'h6: return dram_pwr_pkg::CMD_ZQ;
            default: return dram_pwr_pkg::CMD_NOP;
        endcase
    endfunction

    wire dram_pwr_pkg::command_e cmd = decode_cmd(pins_reg); // see R23
    wire gate_now = pins_reg.clock_gate;
    wire gate_fall = gate_prev_reg && !gate_now; // see R01
    wire gate_rise = !gate_prev_reg && gate_now; // see R01
    wire gate_high = gate_prev_reg && gate_now;
    wire is_deselect = (cmd == dram_pwr_pkg::CMD_DESELECT);
    wire exit_cmd_ok = is_deselect || (gear_reg && cmd == dram_pwr_pkg::CMD_NOP);
    wire banks_closed = (open_banks_reg == 8'h00);
    wire [7:0] bank_bit = 8'h01 << pins_reg.bank_select;
    wire all_banks = pins_reg.op_code[10];
    wire mode_cmd = gate_high && cmd == dram_pwr_pkg::CMD_MODE_WR && state_reg == dram_pwr_pkg::ST_IDLE;
    wire [2:0] mode_idx = pins_reg.bank_select;
    wire nom_before = |mode_regs_reg[dram_pwr_pkg::MODE_REG_NOM_TERM][dram_pwr_pkg::NOM_TERM_MSB:dram_pwr_pkg::NOM_TERM_LSB];
    wire nom_after = (mode_idx == 3'h1) ?
        (|pins_reg.op_code[dram_pwr_pkg::NOM_TERM_MSB:dram_pwr_pkg::NOM_TERM_LSB]) : nom_before;
    wire term_ignored = mode_cmd && !nom_before && !nom_after; // see R20

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            dram_pwr_pkg::ST_IDLE:
            begin
                if (gate_fall && cmd == dram_pwr_pkg::CMD_REFRESH)
                    state_next = dram_pwr_pkg::ST_SELF_REF; // see R04
                else if (gate_fall && is_deselect)
                    state_next = dram_pwr_pkg::ST_PRE_PD;
                else if (gate_high && cmd == dram_pwr_pkg::CMD_ACTIVATE)
                    state_next = dram_pwr_pkg::ST_ACTIVE;
            end
            dram_pwr_pkg::ST_ACTIVE:
            begin
                if (gate_fall && is_deselect)
                    state_next = dram_pwr_pkg::ST_ACT_PD; // see R06
                else if (gate_high && (cmd == dram_pwr_pkg::CMD_READ || cmd == dram_pwr_pkg::CMD_WRITE ||
                                       cmd == dram_pwr_pkg::CMD_PRECHARGE))
                    state_next = dram_pwr_pkg::ST_BUSY;
            end
            dram_pwr_pkg::ST_BUSY:
            begin
                // Entry mid-operation settles by the bank state at the cycle of entry.
                if (gate_fall && is_deselect)
                    state_next = banks_closed ? dram_pwr_pkg::ST_PRE_PD : dram_pwr_pkg::ST_ACT_PD; // see R06
                else if (busy_count_reg == 4'h0)
                    state_next = banks_closed ? dram_pwr_pkg::ST_IDLE : dram_pwr_pkg::ST_ACTIVE;
            end
            dram_pwr_pkg::ST_ACT_PD:
            begin
                if (gate_rise && is_deselect)
                    state_next = dram_pwr_pkg::ST_ACTIVE; // see R02
            end
            dram_pwr_pkg::ST_PRE_PD:
            begin
                if (gate_rise && is_deselect)
                    state_next = dram_pwr_pkg::ST_IDLE; // see R02
            end
            dram_pwr_pkg::ST_SELF_REF:
            begin
                if (gate_rise && exit_cmd_ok)
                    state_next = dram_pwr_pkg::ST_IDLE; // see R03
            end
            default:
                state_next = dram_pwr_pkg::ST_IDLE;
        endcase
    end

    // A change of clock gate that the table does not list is flagged, state kept.
    wire illegal = (gate_fall || gate_rise) && (state_next == state_reg); // see R24
    wire in_pd = (state_reg == dram_pwr_pkg::ST_ACT_PD) || (state_reg == dram_pwr_pkg::ST_PRE_PD);

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pins_meta_reg <= dram_pwr_pkg::PINS_AT_RESET;
            pins_reg <= dram_pwr_pkg::PINS_AT_RESET;
            term_meta_reg <= 1'b0;
            term_reg <= 1'b0;
            gear_meta_reg <= 1'b0;
            gear_reg <= 1'b0;
        end
        else
        begin
            pins_meta_reg <= cmd_pins_in;
            pins_reg <= pins_meta_reg;
            term_meta_reg <= termination_control_in;
            term_reg <= term_meta_reg;
            gear_meta_reg <= gear_down_in;
            gear_reg <= gear_meta_reg;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            // Idle implies a high clock gate; a low reset value would fake a rise.
            gate_prev_reg <= 1'b1;
            state_reg <= dram_pwr_pkg::ST_IDLE;
            unsupported_reg <= 1'b0;
        end
        else
        begin
            gate_prev_reg <= gate_now; // see R01
            state_reg <= state_next; // see R24
            unsupported_reg <= illegal;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy_count_reg <= 4'h0;
            open_banks_reg <= 8'h00;
        end
        else
        begin
            if (state_next == dram_pwr_pkg::ST_BUSY && state_reg != dram_pwr_pkg::ST_BUSY)
                busy_count_reg <= (cmd == dram_pwr_pkg::CMD_PRECHARGE) ?
                    dram_pwr_pkg::PRECHARGE_BUSY_CYCLES : dram_pwr_pkg::BURST_BUSY_CYCLES;
            else if (busy_count_reg != 4'h0)
                busy_count_reg <= busy_count_reg - 4'h1;
            if (gate_high && cmd == dram_pwr_pkg::CMD_ACTIVATE)
                open_banks_reg <= open_banks_reg | bank_bit;
            else if (gate_high && cmd == dram_pwr_pkg::CMD_PRECHARGE)
                open_banks_reg <= all_banks ? 8'h00 : (open_banks_reg & ~bank_bit);
        end
    end

    // Mode storage only; the array is not touched by a mode write.
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int i = 0; i < dram_pwr_pkg::MODE_REG_COUNT; i++)
                mode_regs_reg[i] <= dram_pwr_pkg::MODE_REG_RESET;
            mode_wr_reg <= 1'b0;
            mode_idx_reg <= 3'h0;
            mode_val_reg <= 14'h0000;
        end
        else
        begin
            mode_wr_reg <= mode_cmd && (mode_idx < 3'h7); // see R11
            if (mode_cmd && mode_idx < 3'h7)
            begin
                // The write-recovery field is only held here; no auto-precharge timing is built in this block.
                mode_regs_reg[mode_idx] <= pins_reg.op_code; // see R11, R14, R22
                mode_idx_reg <= mode_idx;
                mode_val_reg <= pins_reg.op_code;
            end
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            refresh_reg <= 1'b0;
            term_en_reg <= 1'b0;
        end
        else
        begin
            // Powered-down states do no refresh; only self-refresh does.
            refresh_reg <= (state_next == dram_pwr_pkg::ST_SELF_REF); // see R07
            term_en_reg <= term_reg && !term_ignored && state_next != dram_pwr_pkg::ST_SELF_REF &&
                nom_after; // see R10
        end
    end

    assign power_state_out = state_reg;
    assign unsupported_out = unsupported_reg;
    assign refresh_active_out = refresh_reg;
    assign termination_enable_out = term_en_reg;
    assign mode_write_out = mode_wr_reg;
    assign mode_index_out = mode_idx_reg;
    assign mode_value_out = mode_val_reg;

    self_ref_idle_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R04
        (state_reg == dram_pwr_pkg::ST_SELF_REF && $past(state_reg) != dram_pwr_pkg::ST_SELF_REF)
        |-> $past(state_reg) == dram_pwr_pkg::ST_IDLE && $past(gate_fall))
        else $error("Self-refresh entered from a non-idle state.");
    pd_no_refresh_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R07
        in_pd |-> !refresh_reg)
        else $error("Refresh active in power-down.");
    sr_no_term_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R10
        state_reg == dram_pwr_pkg::ST_SELF_REF |-> !term_en_reg)
        else $error("Termination enabled in self-refresh.");
    pd_entry_kind_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R06
        (state_reg == dram_pwr_pkg::ST_BUSY && gate_fall && is_deselect && banks_closed)
        |=> state_reg == dram_pwr_pkg::ST_PRE_PD)
        else $error("Closed banks did not give precharge power-down.");
    mode_store_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R11
        mode_wr_reg |-> mode_regs_reg[mode_idx_reg] == mode_val_reg)
        else $error("Mode register not updated.");
    gate_edge_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R01
        (state_reg == dram_pwr_pkg::ST_PRE_PD && gate_rise && is_deselect) |=> state_reg == dram_pwr_pkg::ST_IDLE)
        else $error("Power-down exit missed.");
    illegal_flag_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // see R24
        illegal |=> unsupported_reg)
        else $error("Unsupported transition not flagged.");
endmodule

// ### hw/dram_pwr_pkg.sv
package dram_pwr_pkg;

    // Power and bank state, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_ACTIVE   = 6'h02,
        ST_ACT_PD   = 6'h04,
        ST_PRE_PD   = 6'h08,
        ST_SELF_REF = 6'h10,
        ST_BUSY     = 6'h20
    } power_state_e;

    // Command pins as sampled at the rising clock edge.
    typedef struct packed {
        logic chip_select_n;
        logic activate_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic clock_gate;
        logic [2:0] bank_select;
        logic [2:0] bank_group_select;
        logic [13:0] op_code;
    } cmd_pins_s;

    typedef enum logic [3:0] {
        CMD_DESELECT  = 4'h0,
        CMD_NOP       = 4'h1,
        CMD_MODE_WR   = 4'h2,
        CMD_REFRESH   = 4'h3,
        CMD_PRECHARGE = 4'h4,
        CMD_ACTIVATE  = 4'h5,
        CMD_WRITE     = 4'h6,
        CMD_READ      = 4'h7,
        CMD_ZQ        = 4'h8,
        CMD_RESERVED  = 4'h9
    } command_e;

    localparam int MODE_REG_COUNT = 7;
    localparam int MODE_REG_WIDTH = 14;
    localparam logic [13:0] MODE_REG_RESET = 14'h0000;
    localparam int CLOCK_PERIOD_PS = 10000;
    // Busy cycles for a burst or a precharge, counted by the device itself.
    localparam logic [3:0] BURST_BUSY_CYCLES = 4'h4;
    localparam logic [3:0] PRECHARGE_BUSY_CYCLES = 4'h2;
    // Position of the nominal termination field in the second mode register.
    localparam int NOM_TERM_LSB = 8;
    localparam int NOM_TERM_MSB = 10;
    localparam int MODE_REG_NOM_TERM = 1;
    localparam logic [7:0] NUM_BANKS = 8'h08;
    // Pins after reset read as a deselect with the clock gate high, so no false gate edge follows reset.
    localparam cmd_pins_s PINS_AT_RESET = 26'h3F00000;

endpackage

// ### test/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model #(
    parameter int MODE_GAP = 8,
    parameter int PULSE_MIN = 3,
    parameter int EXIT_WAIT = 16
) (
    input wire logic clock_in,
    output dram_pwr_pkg::cmd_pins_s cmd_pins_out
);
    dram_pwr_pkg::cmd_pins_s pins_reg;
    assign cmd_pins_out = pins_reg;
    initial
    begin
        pins_reg = '0;
        pins_reg.chip_select_n = 1'b1;
        pins_reg.clock_gate = 1'b1;
    end
    // One command for one cycle, then deselect; released bank-select and op-code pins show the inverse.
    task automatic drive(input logic [4:0] ctl, input logic cke, input logic [2:0] idx, input logic [13:0] op);
        @(posedge clock_in);
        #1;
        {pins_reg.chip_select_n, pins_reg.activate_n, pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} = ctl;
        pins_reg.clock_gate = cke;
        pins_reg.bank_select = idx;
        pins_reg.bank_group_select = {2'h0, idx[2]};
        pins_reg.op_code = op;
        @(posedge clock_in);
        #1;
        pins_reg.chip_select_n = 1'b1;
        pins_reg.bank_select = ~idx;
        pins_reg.op_code = ~op;
    endtask
    task automatic mode_write(input logic [2:0] idx, input logic [13:0] op);
        drive(5'h08, 1'b1, idx, op);
        repeat (MODE_GAP) @(posedge clock_in);
        #1;
    endtask
    // Clock gate edges carry the given command and are then held for the minimum pulse.
    task automatic gate(input logic cke, input logic [4:0] ctl);
        drive(ctl, cke, 3'h0, 14'h0000);
        repeat (PULSE_MIN) @(posedge clock_in);
        #1;
    endtask
    // Self-refresh exit, then deselect only until the locked exit wait has passed.
    task automatic leave_self_refresh(input logic [4:0] ctl);
        gate(1'b1, ctl);
        repeat (EXIT_WAIT) @(posedge clock_in);
        #1;
    endtask
endmodule

// ### test/dram_power_state_and_mode_program_bench.sv
`timescale 1ns/1ps
module dram_power_state_and_mode_program_bench;
    localparam logic [4:0] C_DES = 5'h1F;
    localparam logic [4:0] C_NOP = 5'h0F;
    localparam logic [4:0] C_MODE_WR = 5'h08;
    localparam int TERMINATION_OFF_LATENCY = 4;
    localparam logic [4:0] C_REF = 5'h09;
    logic clock_in;
    logic arst_n_in;
    logic termination_control_in;
    logic gear_down_in;
    dram_pwr_pkg::cmd_pins_s cmd_pins;
    logic [5:0] power_state;
    logic unsupported;
    logic refresh_active;
    logic term_en;
    logic mode_write;
    logic [2:0] mode_index;
    logic [13:0] mode_value;
    int num_errors = 0;
    int checks_done = 0;
    int mw_count = 0;
    int bad_count = 0;
    ctrl_model i_ctrl_model (
        .clock_in(clock_in),
        .cmd_pins_out(cmd_pins)
    );
    dram_power_state_and_mode_program i_dram_power_state_and_mode_program (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .cmd_pins_in(cmd_pins),
        .termination_control_in(termination_control_in),
        .gear_down_in(gear_down_in),
        .power_state_out(power_state),
        .unsupported_out(unsupported),
        .refresh_active_out(refresh_active),
        .termination_enable_out(term_en),
        .mode_write_out(mode_write),
        .mode_index_out(mode_index),
        .mode_value_out(mode_value)
    );
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        if (mode_write === 1'b1)
            mw_count++;
        if (unsupported === 1'b1)
            bad_count++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks_done++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic expect_state(input logic [5:0] st, input logic rf, input logic te);
        repeat (5) @(posedge clock_in);
        #1;
        check({10'h000, power_state}, {10'h000, st});
        check({15'h0000, refresh_active}, {15'h0000, rf});
        check({15'h0000, term_en}, {15'h0000, te});
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #200000;
        num_errors++;
        conclude();
    end
    initial
    begin
        arst_n_in = 1'b0;
        termination_control_in = 1'b0;
        gear_down_in = 1'b0;
        repeat (8) @(posedge clock_in);
        #1;
        check({10'h000, power_state}, 16'h0001);
        check({2'h0, mode_value}, 16'h0000);
        arst_n_in = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            i_ctrl_model.mode_write(3'(i), {3'(i), 11'h0A5});
            check(16'(mw_count), 16'(i + 1));
            check({13'h0000, mode_index}, 16'(i));
            check({2'h0, mode_value}, {2'h0, 3'(i), 11'h0A5});
        end
        i_ctrl_model.mode_write(3'h7, 14'h3FFF);
        check(16'(mw_count), 16'h0007);
        termination_control_in = 1'b1;
        expect_state(6'h01, 1'b0, 1'b0);
        // Termination stays low across a write that changes the nominal value.
        termination_control_in = 1'b0;
        repeat (TERMINATION_OFF_LATENCY + 1) @(posedge clock_in);
        i_ctrl_model.mode_write(3'h1, 14'h0300);
        termination_control_in = 1'b1;
        expect_state(6'h01, 1'b0, 1'b1);
        i_ctrl_model.gate(1'b0, C_DES);
        expect_state(6'h08, 1'b0, 1'b1);
        i_ctrl_model.gate(1'b1, C_DES);
        expect_state(6'h01, 1'b0, 1'b1);
        i_ctrl_model.gate(1'b0, C_REF);
        expect_state(6'h10, 1'b1, 1'b0);
        // Termination is raised again only once the locked exit wait is over.
        termination_control_in = 1'b0;
        i_ctrl_model.leave_self_refresh(C_DES);
        termination_control_in = 1'b1;
        expect_state(6'h01, 1'b0, 1'b1);
        termination_control_in = 1'b0;
        gear_down_in = 1'b1;
        i_ctrl_model.gate(1'b0, C_REF);
        i_ctrl_model.leave_self_refresh(C_NOP);
        expect_state(6'h01, 1'b0, 1'b0);
        gear_down_in = 1'b0;
        i_ctrl_model.drive(5'h07, 1'b1, 3'h0, 14'h0000);
        expect_state(6'h02, 1'b0, 1'b0);
        i_ctrl_model.mode_write(3'h2, 14'h0011);
        check(16'(mw_count), 16'h0008);
        i_ctrl_model.gate(1'b0, C_DES);
        expect_state(6'h04, 1'b0, 1'b0);
        i_ctrl_model.gate(1'b1, C_DES);
        expect_state(6'h02, 1'b0, 1'b0);
        i_ctrl_model.drive(5'h0C, 1'b1, 3'h0, 14'h0000);
        i_ctrl_model.gate(1'b0, C_DES);
        expect_state(6'h04, 1'b0, 1'b0);
        i_ctrl_model.gate(1'b1, C_DES);
        i_ctrl_model.drive(5'h0A, 1'b1, 3'h0, 14'h0400);
        i_ctrl_model.gate(1'b0, C_DES);
        expect_state(6'h08, 1'b0, 1'b0);
        i_ctrl_model.gate(1'b1, C_DES);
        expect_state(6'h01, 1'b0, 1'b0);
        i_ctrl_model.gate(1'b0, C_REF);
        i_ctrl_model.gate(1'b1, C_MODE_WR);
        expect_state(6'h10, 1'b1, 1'b0);
        check(16'(bad_count), 16'h0001);
        check(16'(mw_count), 16'h0008);
        i_ctrl_model.gate(1'b0, C_DES);
        i_ctrl_model.leave_self_refresh(C_DES);
        expect_state(6'h01, 1'b0, 1'b0);
        // A second reset clears the mode registers; only mode register 0 is written again before the last check.
        arst_n_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        check({10'h000, power_state}, 16'h0001);
        check({2'h0, mode_value}, 16'h0000);
        check({15'h0000, unsupported}, 16'h0000);
        arst_n_in = 1'b1;
        termination_control_in = 1'b1;
        i_ctrl_model.mode_write(3'h0, 14'h0000);
        check(16'(mw_count), 16'h0009);
        check({13'h0000, mode_index}, 16'h0000);
        expect_state(6'h01, 1'b0, 1'b0);
        conclude();
    end
endmodule
